// ===== hw/ctc_pkg.sv
package ctc_pkg;
    // register byte offsets
    localparam logic [3:0] CTC_OFF_CTRL1 = 4'h0;
    localparam logic [3:0] CTC_OFF_CTRL0 = 4'h4;
    localparam logic [3:0] CTC_OFF_CMPA = 4'h8;
    localparam logic [3:0] CTC_OFF_STAT = 4'hc;
    // secondary control field positions
    localparam int CTC_MODE_HI = 7;
    localparam int CTC_MODE_LO = 6;
    localparam int CTC_FUNC_HI = 5;
    localparam int CTC_FUNC_LO = 4;
    localparam int CTC_INIT_BIT = 3;
    localparam int CTC_POL_BIT = 2;
    localparam int CTC_DPX_BIT = 1;
    localparam int CTC_CCLR_BIT = 0;
    // primary control field positions
    localparam int CTC_RUN_BIT = 3;
    localparam int CTC_PRE_HI = 2;
    localparam int CTC_CMPP_HI = 6;
    localparam int CTC_CMPP_LO = 4;
    // reset values
    localparam logic [7:0] CTC_CTRL1_RST = 8'h00;
    localparam logic [7:0] CTC_CTRL0_RST = 8'h00;
    localparam logic [9:0] CTC_CMPA_RST = 10'h000;
    // mode encodings
    localparam logic [1:0] CTC_MODE_CMP = 2'h0;
    localparam logic [1:0] CTC_MODE_PWM = 2'h2;
    localparam logic [1:0] CTC_MODE_TMR = 2'h3;
    // compare match pin functions
    localparam logic [1:0] CTC_FN_NONE = 2'h0;
    localparam logic [1:0] CTC_FN_LOW = 2'h1;
    localparam logic [1:0] CTC_FN_HIGH = 2'h2;
    localparam logic [1:0] CTC_FN_TOGGLE = 2'h3;
    // pwm pin functions
    localparam logic [1:0] CTC_PWM_INACT = 2'h0;
    localparam logic [1:0] CTC_PWM_ACT = 2'h1;
    localparam logic [1:0] CTC_PWM_RUN = 2'h2;
    // axi responses
    localparam logic [1:0] CTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] CTC_RESP_SLVERR = 2'h2;
endpackage : ctc_pkg

// ===== hw/ctc_prescaler.sv
// divides aclk into a one-cycle count enable
module ctc_prescaler #(
    parameter int DIV_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic [DIV_W-1:0] mask;

    // sel chooses divide by 2**sel
    assign mask = DIV_W'((1 << sel) - 1);
    assign cnt_nxt = run ? cnt_r + 1'b1 : '0;

    // divider counter and enable pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick <= run && ((cnt_r & mask) == mask);
        end
    end
endmodule // ctc_prescaler

// ===== hw/ctc_timer.sv
// Notes on behaviour
// - mode bits: 00 compare, 10 pwm, 11 timer
// - compare A match drives pin low/high/toggle
// - run enable rising edge loads initial level in compare mode
// - pwm function: enable waveform or fixed level
// - polarity bit inverts both output pins
// - polarity ignored in timer/counter mode
// - swap bit exchanges period and duty registers
// - clear select one: clear on A match
// - clear select zero: clear on P match/overflow
// - overflow clear only when P is zero
// - pwm ignores clear select, uses period register
module ctc_timer #(
    parameter int CNT_W = 10,
    parameter int PW = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic timer_output_pin_zero,
    output logic timer_output_pin_one,
    output logic pin_drive_en
);
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl0_r;
    logic [CNT_W-1:0] cmpa_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic raw_r;
    logic raw_nxt;
    logic run_d_r;
    logic a_seen_r;
    logic p_seen_r;
    logic [3:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic tick;

    // control field views
    logic [1:0] op_mode;
    logic [1:0] pin_func;
    wire initial_level_bit = ctrl1_r[ctc_pkg::CTC_INIT_BIT];
    wire polarity_invert_bit = ctrl1_r[ctc_pkg::CTC_POL_BIT];
    wire period_duty_swap_bit = ctrl1_r[ctc_pkg::CTC_DPX_BIT];
    wire clear_source_select_bit = ctrl1_r[ctc_pkg::CTC_CCLR_BIT];
    wire timer_run_enable = ctrl0_r[ctc_pkg::CTC_RUN_BIT];
    wire [PW-1:0] compare_value_p = ctrl0_r[ctc_pkg::CTC_CMPP_HI:ctc_pkg::CTC_CMPP_LO];
    wire [CNT_W-1:0] compare_value_a = cmpa_r;
    assign op_mode = ctrl1_r[ctc_pkg::CTC_MODE_HI:ctc_pkg::CTC_MODE_LO];
    assign pin_func = ctrl1_r[ctc_pkg::CTC_FUNC_HI:ctc_pkg::CTC_FUNC_LO];

    // mode decode
    wire mode_cmp = (op_mode == ctc_pkg::CTC_MODE_CMP);
    wire mode_pwm = (op_mode == ctc_pkg::CTC_MODE_PWM);
    wire mode_tmr = (op_mode == ctc_pkg::CTC_MODE_TMR);
    wire run_rise = timer_run_enable && !run_d_r;

    ctc_prescaler #(
        .DIV_W(8)
    ) u_pre (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(timer_run_enable),
        .sel(ctrl0_r[ctc_pkg::CTC_PRE_HI:0]),
        .tick(tick)
    );

    // comparators: P matches the top PW counter bits with the low bits zero, A sees all
    wire [PW-1:0] cnt_top = cnt_r[CNT_W-1:CNT_W-PW];
    wire p_zero = (compare_value_p == '0);
    wire cnt_max = (cnt_r == {CNT_W{1'b1}});
    wire p_match = !p_zero && (cnt_top == compare_value_p) && (cnt_r[CNT_W-PW-1:0] == '0);
    wire a_match = (cnt_r == compare_value_a);
    wire a_event = tick && a_match;
    wire p_event = tick && p_match;
    wire ovf_event = tick && cnt_max;

    // pwm roles: period register clears, duty register sets the width
    wire [CNT_W-1:0] p_full = {compare_value_p, {(CNT_W-PW){1'b0}}};
    wire [CNT_W-1:0] period_val = period_duty_swap_bit ? compare_value_a : p_full;
    wire [CNT_W-1:0] duty_val = period_duty_swap_bit ? p_full : compare_value_a;
    wire pwm_clear = period_duty_swap_bit ? a_event : (p_zero ? ovf_event : p_event);
    // non-pwm clear source
    wire cmp_clear = clear_source_select_bit ? a_event
        : (p_zero ? ovf_event : p_event);
    wire cnt_clear = mode_pwm ? pwm_clear : cmp_clear;
    wire pwm_high_phase = (cnt_r < duty_val) || (duty_val >= period_val && period_val != '0);

    // counter next value
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (!timer_run_enable)
            cnt_nxt = '0;
        else if (cnt_clear)
            cnt_nxt = '0;
        else if (tick)
            cnt_nxt = cnt_r + 1'b1;
    end

    // raw pin level before polarity
    always_comb
    begin
        raw_nxt = raw_r;
        if (mode_cmp)
        begin
            if (run_rise)
                raw_nxt = initial_level_bit;
            else if (a_event && timer_run_enable)
            begin
                unique case (pin_func)
                    ctc_pkg::CTC_FN_NONE: raw_nxt = raw_r;
                    ctc_pkg::CTC_FN_LOW: raw_nxt = 1'b0;
                    ctc_pkg::CTC_FN_HIGH: raw_nxt = 1'b1;
                    ctc_pkg::CTC_FN_TOGGLE: raw_nxt = !raw_r;
                endcase
            end
        end
        else if (mode_pwm)
        begin
            unique case (pin_func)
                ctc_pkg::CTC_PWM_INACT: raw_nxt = !initial_level_bit;
                ctc_pkg::CTC_PWM_ACT: raw_nxt = initial_level_bit;
                ctc_pkg::CTC_PWM_RUN: raw_nxt = timer_run_enable && pwm_high_phase ? initial_level_bit
                    : !initial_level_bit;
                default: raw_nxt = raw_r;
            endcase
        end
    end

    // pin output with polarity, not applied in timer/counter mode
    wire pin_level = (polarity_invert_bit && !mode_tmr) ? !raw_r : raw_r;

    // timer core registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= '0;
            raw_r <= 1'b0;
            run_d_r <= 1'b0;
            timer_output_pin_zero <= 1'b0;
            timer_output_pin_one <= 1'b0;
            pin_drive_en <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            raw_r <= raw_nxt;
            run_d_r <= timer_run_enable;
            timer_output_pin_zero <= pin_level;
            timer_output_pin_one <= pin_level;
            pin_drive_en <= !mode_tmr && (op_mode != 2'h1);
        end
    end

    // write channel acceptance, either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    wire wsel_c1 = (awaddr_r[3:2] == ctc_pkg::CTC_OFF_CTRL1[3:2]);
    wire wsel_c0 = (awaddr_r[3:2] == ctc_pkg::CTC_OFF_CTRL0[3:2]);
    wire wsel_a = (awaddr_r[3:2] == ctc_pkg::CTC_OFF_CMPA[3:2]);
    wire wsel_ok = wsel_c1 || wsel_c0 || wsel_a;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ctc_pkg::CTC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !aw_take && !s_axi_bvalid;
            s_axi_wready <= !w_held_r && !w_take && !s_axi_bvalid;
            if (aw_take)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wsel_ok ? ctc_pkg::CTC_RESP_OKAY : ctc_pkg::CTC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // register writes, byte lane 0 and 1
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl1_r <= ctc_pkg::CTC_CTRL1_RST;
            ctrl0_r <= ctc_pkg::CTC_CTRL0_RST;
            cmpa_r <= ctc_pkg::CTC_CMPA_RST;
        end
        else if (wr_go)
        begin
            if (wsel_c1 && wstrb_r[0])
                ctrl1_r <= wdata_r[7:0];
            if (wsel_c0 && wstrb_r[0])
                ctrl0_r <= wdata_r[7:0];
            if (wsel_a && wstrb_r[0])
                cmpa_r[7:0] <= wdata_r[7:0];
            if (wsel_a && wstrb_r[1])
                cmpa_r[CNT_W-1:8] <= wdata_r[CNT_W-1:8];
        end
    end

    // sticky match status, set wins over clear on read
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire rsel_st = (s_axi_araddr[3:2] == ctc_pkg::CTC_OFF_STAT[3:2]);
    wire clr_st = rd_take && rsel_st;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            a_seen_r <= 1'b0;
            p_seen_r <= 1'b0;
        end
        else
        begin
            a_seen_r <= a_event || (a_seen_r && !clr_st);
            p_seen_r <= (p_event && !(clear_source_select_bit && !mode_pwm)) || (p_seen_r && !clr_st);
        end
    end

    // read data mux
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr[3:2])
            ctc_pkg::CTC_OFF_CTRL1[3:2]: rd_mux = {24'h00_0000, ctrl1_r};
            ctc_pkg::CTC_OFF_CTRL0[3:2]: rd_mux = {24'h00_0000, ctrl0_r};
            ctc_pkg::CTC_OFF_CMPA[3:2]: rd_mux = 32'(cmpa_r);
            ctc_pkg::CTC_OFF_STAT[3:2]: rd_mux = {4'h0, 6'(cnt_r), 20'h0_0000, p_seen_r, a_seen_r};
        endcase
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ctc_pkg::CTC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !rd_take;
            if (rd_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? ctc_pkg::CTC_RESP_OKAY : ctc_pkg::CTC_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // ctc_timer

// ===== testbench/ctc_timer_assertions.sv
module ctc_timer_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_output_pin_zero,
    input wire logic timer_output_pin_one,
    input wire logic pin_drive_en
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [3:0] wa_r;
    logic [7:0] wd_r;
    // last accepted write address and low data byte
    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wa_r <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            wd_r <= s_axi_wdata[7:0];
    end
    // completed control write and the pin enable its mode implies
    wire logic wr_ctrl1 = s_axi_bvalid && s_axi_bready && wa_r == ctc_pkg::CTC_OFF_CTRL1
        && s_axi_bresp == ctc_pkg::CTC_RESP_OKAY;
    wire logic en_exp = wd_r[7:6] == ctc_pkg::CTC_MODE_CMP || wd_r[7:6] == ctc_pkg::CTC_MODE_PWM;
    // pins, mode decode and bus handshakes
    property p_drive_en; wr_ctrl1 |=> pin_drive_en == en_exp; endproperty
    a_drive_en: assert property (p_drive_en) else $error("pin enable does not match mode");
    property p_pins_same; timer_output_pin_zero == timer_output_pin_one; endproperty
    a_pins_same: assert property (p_pins_same) else $error("output pins differ");
    // both held at the take edge, response registered one edge after that
    property p_b_after_w;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_after_w: assert property (p_b_after_w) else $error("write response late");
    property p_r_after_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'h0; endproperty
    a_r_after_ar: assert property (p_r_after_ar) else $error("read response late or not okay");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped or changed");
    property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_block: assert property (p_w_block) else $error("write accepted while response pending");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted while response pending");
    // main scenarios reached
    c_wr_ctrl1: cover property (wr_ctrl1);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_pin_rise: cover property ($rose(timer_output_pin_zero));
endmodule // ctc_timer_assertions

bind ctc_timer ctc_timer_assertions i_chk (.*);

// ===== testbench/tb_compact_timer_control_one.sv
module tb_compact_timer_control_one;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] c1; logic pin; logic en; logic chk;} ctc_row_t;
    typedef struct {logic [7:0] c1; logic [2:0] p; logic [9:0] a; int tlo; int thi; int hlo; int hhi;} ctc_wave_t;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic timer_output_pin_zero, timer_output_pin_one, pin_drive_en;
    int errors = 0, tests_run = 0, tog, hi;
    // static levels: control value, pin level, pin enable, pin checked
    ctc_row_t rows[9] = '{'{8'h00, 1'h0, 1'h1, 1'h1}, '{8'h08, 1'h1, 1'h1, 1'h1}, '{8'h0c, 1'h0, 1'h1, 1'h1},
        '{8'h04, 1'h1, 1'h1, 1'h1}, '{8'h88, 1'h0, 1'h1, 1'h1}, '{8'h9c, 1'h0, 1'h1, 1'h1},
        '{8'h94, 1'h1, 1'h1, 1'h1}, '{8'hc4, 1'h0, 1'h0, 1'h1}, '{8'h40, 1'h0, 1'h0, 1'h1}};
    // waveforms over 512 cycles: toggle and high-cycle ranges
    ctc_wave_t waves[10] = '{'{8'h08, 3'h0, 10'h9, 0, 0, 512, 512}, '{8'h18, 3'h0, 10'h9, 1, 1, 0, 20},
        '{8'h20, 3'h0, 10'h9, 1, 1, 490, 512}, '{8'h31, 3'h0, 10'h9, 40, 53, 200, 312},
        '{8'h30, 3'h0, 10'h9, 1, 1, 490, 512}, '{8'h30, 3'h1, 10'h9, 3, 5, 0, 512},
        '{8'ha8, 3'h1, 10'h20, 6, 10, 100, 160}, '{8'ha9, 3'h1, 10'h20, 6, 10, 100, 160},
        '{8'haa, 3'h1, 10'h20, 0, 2, 495, 512}, '{8'hac, 3'h1, 10'h20, 6, 10, 350, 415}};

    ctc_timer i_dut (.*);

    // 250 MHz clock
    always #2 aclk = ~aclk;

    task automatic stop_test();
        $display("comparisons %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_rng(input string n, input int lo, input int hh, input int g);
        tests_run++;
        if (g < lo || g > hh)
        begin
            errors++;
            $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hh, g);
        end
    endtask

    // address and data offered together, held until each is taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask

    // stop, configure, then start with prescale of one
    task automatic start(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a);
        axi_wr(ctc_pkg::CTC_OFF_CTRL0, 32'h0);
        axi_wr(ctc_pkg::CTC_OFF_CTRL1, {24'h0, c1});
        axi_wr(ctc_pkg::CTC_OFF_CMPA, {22'h0, a});
        axi_wr(ctc_pkg::CTC_OFF_CTRL0, {25'h0, p, 4'h8});
    endtask

    // counts pin changes and high cycles after the start settles
    task automatic count(input int n);
        logic last;
        repeat (3) @(posedge aclk);
        last = timer_output_pin_zero;
        tog = 0;
        hi = 0;
        repeat (n)
        begin
            @(posedge aclk);
            tog += int'(timer_output_pin_zero != last);
            hi += int'(timer_output_pin_zero);
            last = timer_output_pin_zero;
        end
    endtask

    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        stop_test();
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 3; i++)
        begin
            axi_rd(4'(i * 4), rd);
            chk("reset value", 32'h0, rd);
        end
        foreach (rows[i])
        begin
            start(rows[i].c1, 3'h0, 10'h3ff);
            repeat (4) @(posedge aclk);
            if (rows[i].chk) chk("pin level", 32'(rows[i].pin), 32'(timer_output_pin_zero));
            chk("pin enable", 32'(rows[i].en), 32'(pin_drive_en));
            axi_rd(ctc_pkg::CTC_OFF_CTRL1, rd);
            chk("control readback", {24'h0, rows[i].c1}, rd);
        end
        foreach (waves[i])
        begin
            start(waves[i].c1, waves[i].p, waves[i].a);
            count(512);
            chk_rng("pin toggles", waves[i].tlo, waves[i].thi, tog);
            chk_rng("high cycles", waves[i].hlo, waves[i].hhi, hi);
        end
        // stop, then both match flags stand once and clear on reading
        axi_wr(ctc_pkg::CTC_OFF_CTRL0, 32'h0);
        chk("write response", 32'(ctc_pkg::CTC_RESP_OKAY), 32'(resp));
        axi_rd(ctc_pkg::CTC_OFF_STAT, rd);
        chk("match flags", 32'h0000_0003, rd);
        axi_rd(ctc_pkg::CTC_OFF_STAT, rd);
        chk("match flags cleared", 32'h0000_0000, rd);
        // status is read only, a write there is refused
        axi_wr(ctc_pkg::CTC_OFF_STAT, 32'h0000_00ff);
        chk("unmapped write response", 32'(ctc_pkg::CTC_RESP_SLVERR), 32'(resp));
        // reset in mid-run clears pins, enable and control
        start(8'h08, 3'h0, 10'h3ff);
        repeat (4) @(posedge aclk);
        chk("pin before reset", 32'h1, 32'(timer_output_pin_zero));
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        chk("pin in reset", 32'h0, 32'(timer_output_pin_zero));
        chk("enable in reset", 32'h0, 32'(pin_drive_en));
        aresetn <= 1'h1;
        axi_rd(ctc_pkg::CTC_OFF_CTRL1, rd);
        chk("control after reset", 32'h0, rd);
        axi_rd(ctc_pkg::CTC_OFF_CTRL0, rd);
        chk("run after reset", 32'h0, rd);
        stop_test();
    end
endmodule // tb_compact_timer_control_one
